//--- hw/wse_wake_event_status_enable.sv
`timescale 1ns/10ps
module wse_wake_event_status_enable
  import wse_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        main_power_reset_in,
  input  wire logic        soft_reset_in,
  input  wire logic        hard_reset_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [3:0]  port3_pin_wake_in,
  input  wire logic        port4_pin1_wake_in,
  input  wire logic        port4_pin3_wake_in,
  input  wire logic [1:0]  port6_pin_wake_in,
  input  wire logic [7:0]  port5_pin_wake_in,
  input  wire logic        printer_acknowledge_n_in,
  input  wire logic        second_uart_irq_in,
  input  wire logic        first_uart_irq_in,
  input  wire logic        floppy_irq_in,
  input  wire logic        mouse_irq_in,
  input  wire logic        keyboard_irq_in,
  input  wire logic        watchdog_event_in,
  input  wire logic        two_wire_controller_event_in,
  input  wire logic        kbd_port_line_a_in,
  input  wire logic        kbd_port_line_b_in,
  input  wire logic        ring_indicate_one_n_in,
  input  wire logic        keyboard_wake_in,
  input  wire logic        mouse_wake_in,
  input  wire logic        specific_key_wake_in,
  input  wire logic        fan_speed_sense_wake_in,
  input  wire logic        ring_indicate_two_n_in,
  output logic             wake_event_out_n,
  output logic             wake_summary_status_out,
  output logic             global_wake_enable_out,
  output logic             irq_out
);

  // status update: clear where software writes one, then let events set
  function automatic logic [7:0] w1c_next(input logic [7:0] cur,
                                          input logic [7:0] set,
                                          input logic       wr,
                                          input logic [7:0] data);
    logic [7:0] clr;
    clr = wr ? data : 8'h00;
    return (cur & ~clr) | set;
  endfunction

  // decode a byte address to a word index, flagging unaligned or unmapped
  function automatic logic mapped(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    if (addr[1:0] != 2'b00) begin
      return 1'b0;
    end
    case (idx)
      IDX_SUMMARY, IDX_GLOBAL_EN, IDX_KBD_STS, IDX_PIN_STS_A, IDX_PIN_STS_B,
      IDX_FN_STS, IDX_SRC_EN_A, IDX_IRQ_STS, IDX_IRQ_MASK, IDX_CONFIG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  logic [7:0] pin_status_a_q;
  logic [7:0] pin_status_b_q;
  logic [7:0] fn_status_q;
  logic [7:0] kbd_status_q;
  logic [7:0] src_enable_a_q;
  logic       global_en_q;
  logic       summary_q;
  logic       par_active_q;
  logic [7:0] pending_q;
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;
  logic [31:0] prdata_q;

  logic [5:0] idx;
  logic       access;
  logic       wr;
  logic [7:0] wdata;
  logic       wr_summary;
  logic       wr_global;
  logic       wr_kbd;
  logic       wr_pin_a;
  logic       wr_pin_b;
  logic       wr_fn;
  logic       wr_en_a;
  logic       wr_irq_sts;
  logic       wr_irq_mask;
  logic       wr_cfg;
  logic       other_reset;
  logic       parallel_irq_source;
  logic [7:0] pin_set_a;
  logic [7:0] pin_set_b;
  logic [7:0] fn_set;
  logic [7:0] kbd_set;
  logic [7:0] pending;
  logic       new_pending;
  logic [3:0] irq_set;
  logic [31:0] rd_mux;

  // apb decode; zero wait states, so the access phase always completes
  assign idx         = paddr_in[7:2];
  assign access      = psel_in && penable_in;
  assign pready_out  = access;
  assign pslverr_out = access && !mapped(paddr_in);
  assign wr          = access && pwrite_in && pstrb_in[0] && mapped(paddr_in);
  assign wdata       = pwdata_in[7:0];
  assign wr_summary  = wr && (idx == IDX_SUMMARY);
  assign wr_global   = wr && (idx == IDX_GLOBAL_EN);
  assign wr_kbd      = wr && (idx == IDX_KBD_STS);
  assign wr_pin_a    = wr && (idx == IDX_PIN_STS_A);
  assign wr_pin_b    = wr && (idx == IDX_PIN_STS_B);
  assign wr_fn       = wr && (idx == IDX_FN_STS);
  assign wr_en_a     = wr && (idx == IDX_SRC_EN_A);
  assign wr_irq_sts  = wr && (idx == IDX_IRQ_STS);
  assign wr_irq_mask = wr && (idx == IDX_IRQ_MASK);
  assign wr_cfg      = wr && (idx == IDX_CONFIG);

  // the non-standby resets only touch event bit 0; everything else rides through
  assign other_reset = main_power_reset_in || soft_reset_in || hard_reset_in;

  // parallel source idles high so a dormant port reads as a pending event
  assign parallel_irq_source = par_active_q ? printer_acknowledge_n_in : 1'b1;

  // event vectors in register bit order
  assign pin_set_a = {port6_pin_wake_in, port4_pin3_wake_in, port4_pin1_wake_in,
                      port3_pin_wake_in};
  assign pin_set_b = port5_pin_wake_in;
  assign fn_set    = {two_wire_controller_event_in, watchdog_event_in, keyboard_irq_in,
                      mouse_irq_in, floppy_irq_in, first_uart_irq_in, second_uart_irq_in,
                      parallel_irq_source};
  // ring indicates are active low lines, so a low level is the event
  assign kbd_set   = {!ring_indicate_two_n_in, fan_speed_sense_wake_in, specific_key_wake_in,
                      mouse_wake_in, keyboard_wake_in, !ring_indicate_one_n_in,
                      kbd_port_line_b_in, kbd_port_line_a_in};

  // pin wake status, standby reset only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_status_a_q <= STS_RESET;
      pin_status_b_q <= STS_RESET;
    end else begin
      pin_status_a_q <= w1c_next(pin_status_a_q, pin_set_a, wr_pin_a, wdata);
      pin_status_b_q <= w1c_next(pin_status_b_q, pin_set_b, wr_pin_b, wdata);
    end
  end

  // function event status; other resets force bit 0 and leave the rest
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fn_status_q <= FN_STS_RESET;
    end else begin
      fn_status_q <= w1c_next(fn_status_q, fn_set, wr_fn, wdata);
      if (other_reset) begin
        fn_status_q[FN_PARALLEL] <= 1'b1;
      end
    end
  end

  // keyboard-side source status that pairs with the enable register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      kbd_status_q <= STS_RESET;
    end else begin
      kbd_status_q <= w1c_next(kbd_status_q, kbd_set, wr_kbd, wdata);
    end
  end

  // enables and configuration, standby reset only
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      src_enable_a_q <= EN_RESET;
      global_en_q    <= 1'b0;
      par_active_q   <= 1'b0;
      irq_mask_q     <= IRQ_RESET;
    end else begin
      if (wr_en_a) begin
        src_enable_a_q <= wdata;
      end
      if (wr_global) begin
        global_en_q <= wdata[GLOBAL_EN_BIT];
      end
      if (wr_cfg) begin
        par_active_q <= wdata[CFG_PAR_ACTIVE];
      end
      if (wr_irq_mask) begin
        irq_mask_q <= wdata[3:0];
      end
    end
  end

  // summary sets on a newly enabled pending source, so a clear holds until the next one
  assign pending     = kbd_status_q & src_enable_a_q;
  assign new_pending = |(pending & ~pending_q);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      summary_q <= 1'b0;
      pending_q <= 8'h00;
    end else begin
      pending_q <= pending;
      if (new_pending) begin
        summary_q <= 1'b1;
      end else if (wr_summary && wdata[SUMMARY_BIT]) begin
        summary_q <= 1'b0;
      end
    end
  end

  // wake pin: needs enabled status, live summary and the global enable
  always_comb begin
    wake_event_out_n = !(global_en_q && summary_q && (|pending));
  end
  assign wake_summary_status_out = summary_q;
  assign global_wake_enable_out  = global_en_q;

  // interrupt status: one sticky bit per event group, set beats clear
  assign irq_set = {(|kbd_set), (|fn_set), (|(pin_set_a | pin_set_b)), new_pending};

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_status_q <= IRQ_RESET;
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_irq_sts ? wdata[3:0] : 4'h0)) | irq_set;
    end
  end
  assign irq_out = |(irq_status_q & irq_mask_q);

  // read mux; reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_SUMMARY:   rd_mux[SUMMARY_BIT] = summary_q;
      IDX_GLOBAL_EN: rd_mux[GLOBAL_EN_BIT] = global_en_q;
      IDX_KBD_STS:   rd_mux[7:0] = kbd_status_q;
      IDX_PIN_STS_A: rd_mux[7:0] = pin_status_a_q;
      IDX_PIN_STS_B: rd_mux[7:0] = pin_status_b_q;
      IDX_FN_STS:    rd_mux[7:0] = fn_status_q;
      IDX_SRC_EN_A:  rd_mux[7:0] = src_enable_a_q;
      IDX_IRQ_STS:   rd_mux[3:0] = irq_status_q;
      IDX_IRQ_MASK:  rd_mux[3:0] = irq_mask_q;
      IDX_CONFIG:    rd_mux[CFG_PAR_ACTIVE] = par_active_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
    if (paddr_in[1:0] != 2'b00) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // read data captured in the setup phase, stable through the access phase
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata_out = prdata_q;

  // ---- checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_kbd_event;
    global_en_q && src_enable_a_q[3] && keyboard_wake_in && !kbd_status_q[3] && !wr;
  endsequence

  sequence s_quiet;
    !wr [*2];
  endsequence

  // raw keyboard event with its enable set, independent of the global gate
  sequence s_kbd_raw;
    src_enable_a_q[3] && keyboard_wake_in && !kbd_status_q[3] && !wr;
  endsequence

  a_status_set_pin: assert property (port5_pin_wake_in[0] |=> pin_status_b_q[0])
    else $error("pin event did not set status");

  a_w1c_clear: assert property (wr_pin_a && wdata[2] && !pin_set_a[2]
                                |=> !pin_status_a_q[2])
    else $error("write one did not clear status");

  a_w0_keep: assert property (wr_pin_b && !wdata[1] && pin_status_b_q[1]
                              |=> pin_status_b_q[1])
    else $error("write zero changed status");

  a_standby_reset: assert property (@(posedge clk_in) disable iff (1'b0)
    !rst_n_in |=> pin_status_a_q == STS_RESET && fn_status_q == FN_STS_RESET
                  && src_enable_a_q == EN_RESET)
    else $error("standby reset values wrong");

  a_other_reset_keep: assert property (other_reset && !wr
    |=> fn_status_q[FN_PARALLEL] && src_enable_a_q == $past(src_enable_a_q)
        && (pin_status_a_q & ~$past(pin_set_a)) == ($past(pin_status_a_q) & ~$past(pin_set_a)))
    else $error("non-standby reset disturbed state");

  a_parallel_idle: assert property (!par_active_q && !wr |=> fn_status_q[FN_PARALLEL])
    else $error("dormant parallel source not set");

  a_wake_assert: assert property (s_kbd_event ##1 s_quiet |-> !wake_event_out_n)
    else $error("enabled event did not pull wake low");

  a_disabled_src: assert property (!src_enable_a_q[2] && !ring_indicate_one_n_in
                                   |=> kbd_status_q[2])
    else $error("disabled source event not recorded");

  a_global_block: assert property (!global_en_q |-> wake_event_out_n)
    else $error("wake low with global enable off");

  a_summary_clear: assert property (wr_summary && wdata[0] && !new_pending
                                    |=> !summary_q && wake_event_out_n)
    else $error("summary clear did not release wake");

  // every port5 event present during a clearing write to pin status B must still land
  a_set_wins: assert property (wr_pin_b
    |=> (pin_status_b_q & $past(pin_set_b)) == $past(pin_set_b))
    else $error("event lost to clear");

  // bit placement of each event group
  a_map_port4: assert property (port4_pin1_wake_in |=> pin_status_a_q[4])
    else $error("port4 pin1 event not in bit 4");

  a_map_port6: assert property (port6_pin_wake_in[0] |=> pin_status_a_q[6])
    else $error("port6 pin0 event not in bit 6");

  a_map_port5: assert property (port5_pin_wake_in[7] |=> pin_status_b_q[7])
    else $error("port5 pin7 event not in bit 7");

  a_map_uart: assert property (second_uart_irq_in |=> fn_status_q[1])
    else $error("second uart event not in bit 1");

  a_map_twowire: assert property (two_wire_controller_event_in |=> fn_status_q[7])
    else $error("two-wire event not in bit 7");

  a_map_ring: assert property (!ring_indicate_two_n_in |=> kbd_status_q[7])
    else $error("ring two event not in bit 7");

  a_fn_w1c: assert property (wr_fn && wdata[7] && !two_wire_controller_event_in
                             |=> !fn_status_q[7])
    else $error("event status write one did not clear");

  a_reset_bit0: assert property (other_reset |=> fn_status_q[FN_PARALLEL])
    else $error("non-standby reset did not set event bit 0");

  // registers that only a write may change, whatever the other resets do
  a_enable_keep: assert property (!wr_en_a
    |=> src_enable_a_q == $past(src_enable_a_q))
    else $error("wake enable changed without a write");

  a_global_keep: assert property (!wr_global
    |=> global_en_q == $past(global_en_q))
    else $error("global enable changed without a write");

  a_summary_set: assert property (s_kbd_raw ##1 !wr |=> summary_q)
    else $error("summary not set by enabled event");

  // interrupt and read path checks
  a_irq_unmask: assert property (wr_irq_mask && wdata[IRQ_PIN] && irq_status_q[IRQ_PIN]
                                 |=> irq_out)
    else $error("unmasked pending interrupt not raised");

  a_irq_sticky: assert property (irq_status_q[IRQ_PIN] && !wr_irq_sts
                                 |=> irq_status_q[IRQ_PIN])
    else $error("interrupt status lost without a clear");

  a_read_hold: assert property (psel_in && penable_in && !pwrite_in |=> $stable(prdata_out))
    else $error("read data moved after the access");

endmodule

//--- include/wse_pkg.sv
// Overview of operation
// - a source's wake event sets its status bit regardless of any enable.
// - writing one clears a status bit; writing zero leaves it alone.
// - pin wake status survives main, soft and hard reset; standby reset zeroes it.
// - status at 07: port3 pins 0-3, port4 pins 1 and 3, port6 pins 0-1.
// - status at 08: port5 pins 0 to 7 in bit order.
// - status at 09: parallel, uart2, uart1, floppy, mouse, keyboard, watchdog, two-wire.
// - parallel source sits at one until the port is activated, then follows acknowledge.
// - event status at 09 resets to 01; bit 0 set by every reset kind.
// - other event status bits ignore main, soft and hard reset.
// - wake output goes low when enable, status, summary and global enable are all one.
// - a disabled source still records status but cannot pull the wake output.
// - enable at 0A: two keyboard lines, ring1, keyboard, mouse, key, fan, ring2.
// - wake enable survives main, soft and hard reset; standby reset zeroes it.
// - global enable at 02 bit 0 gates the wake output.
// - summary at 00 sets on would-be wake; writing one clears it and stops wake.
package wse_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SUMMARY   = 6'h00;
  localparam logic [5:0] IDX_GLOBAL_EN = 6'h02;
  localparam logic [5:0] IDX_KBD_STS   = 6'h04;
  localparam logic [5:0] IDX_PIN_STS_A = 6'h07;
  localparam logic [5:0] IDX_PIN_STS_B = 6'h08;
  localparam logic [5:0] IDX_FN_STS    = 6'h09;
  localparam logic [5:0] IDX_SRC_EN_A  = 6'h0a;
  localparam logic [5:0] IDX_IRQ_STS   = 6'h10;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h11;
  localparam logic [5:0] IDX_CONFIG    = 6'h12;

  // reset values on standby power-on reset
  localparam logic [7:0] STS_RESET     = 8'h00;
  localparam logic [7:0] FN_STS_RESET  = 8'h01;
  localparam logic [7:0] EN_RESET      = 8'h00;
  localparam logic [3:0] IRQ_RESET     = 4'h0;

  // field positions
  localparam int SUMMARY_BIT    = 0;
  localparam int GLOBAL_EN_BIT  = 0;
  localparam int FN_PARALLEL    = 0;
  localparam int CFG_PAR_ACTIVE = 0;
  localparam int IRQ_SUMMARY    = 0;
  localparam int IRQ_PIN        = 1;
  localparam int IRQ_FN         = 2;
  localparam int IRQ_KBD        = 3;

endpackage

//--- tb/wse_wake_event_status_enable_tb.sv
`timescale 1ns/10ps
module wse_wake_event_status_enable_tb;
  import wse_pkg::*;
  logic        clk_in, rst_n_in, mpr, srst, hrst, psel, pen, pwr, ack_n, pready, pslverr;
  logic [7:0]  paddr, p5, kb;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0]  pstrb, p3;
  logic [1:0]  p6;
  logic [6:0]  fn;
  logic        p41, p43, wake_n, summ, gen, irq, er;
  int          m[0:63];
  int          num_errors, comparisons, seed, i;
  wse_wake_event_status_enable i_wse_wake_event_status_enable (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .main_power_reset_in(mpr), .soft_reset_in(srst),
    .hard_reset_in(hrst), .paddr_in(paddr), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .port3_pin_wake_in(p3),
    .port4_pin1_wake_in(p41), .port4_pin3_wake_in(p43), .port6_pin_wake_in(p6),
    .port5_pin_wake_in(p5), .printer_acknowledge_n_in(ack_n), .second_uart_irq_in(fn[0]),
    .first_uart_irq_in(fn[1]), .floppy_irq_in(fn[2]), .mouse_irq_in(fn[3]),
    .keyboard_irq_in(fn[4]), .watchdog_event_in(fn[5]), .two_wire_controller_event_in(fn[6]),
    .kbd_port_line_a_in(kb[0]), .kbd_port_line_b_in(kb[1]), .ring_indicate_one_n_in(~kb[2]),
    .keyboard_wake_in(kb[3]), .mouse_wake_in(kb[4]), .specific_key_wake_in(kb[5]),
    .fan_speed_sense_wake_in(kb[6]), .ring_indicate_two_n_in(~kb[7]),
    .wake_event_out_n(wake_n), .wake_summary_status_out(summ),
    .global_wake_enable_out(gen), .irq_out(irq));
  // free-running bench clock, 40 ns period
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // model: idle parallel source keeps event bit 0 set while the port is inactive
  function automatic void mfix();
    if (m[18][0] == 0) m[9] |= 1;
  endfunction
  function automatic void mreset();
    foreach (m[k]) m[k] = 0;
    m[9] = 1;
  endfunction
  // one apb transfer; inj drives a port5 event only during the access cycle
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                     input logic [3:0] st, input logic [7:0] inj);
    int n;
    @(posedge clk_in);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= {idx, 2'b00};
    pwdata <= {$random(seed) & 32'hffffff00} | {24'h0, d}; pstrb <= st;
    @(posedge clk_in);
    pen <= 1'b1; p5 <= inj;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata; er = pslverr;
    psel <= 1'b0; pen <= 1'b0; p5 <= 8'h00;
    if (n >= 50) chk("pready", 0, 1);
    if (w && st[0]) begin
      if (idx inside {6'h02, 6'h0a, 6'h11, 6'h12}) m[idx] = d;
      if (idx inside {6'h04, 6'h07, 6'h08, 6'h09}) m[idx] &= ~d;
      if (idx == 6'h08) m[8] |= inj;
    end
    mfix();
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hf, 8'h00);
  endtask
  task automatic rdm(input logic [5:0] idx);
    apb(1'b0, idx, 8'h00, 4'h0, 8'h00);
    chk("pslverr", er, 0);
    chk($sformatf("reg %h", idx), rd, m[idx]);
  endtask
  // one-cycle event on the chosen sources
  task automatic pin(input logic [31:0] pv, input logic [7:0] p5v, input logic [7:0] kv,
                     input logic [6:0] fv);
    @(posedge clk_in);
    {p6, p43, p41, p3} <= pv[7:0]; p5 <= p5v; kb <= kv; fn <= fv;
    @(posedge clk_in);
    {p6, p43, p41, p3} <= 8'h00; p5 <= 8'h00; kb <= 8'h00; fn <= 7'h00;
    m[7] |= pv[7:0]; m[8] |= p5v; m[4] |= kv; m[9] |= {fv, 1'b0};
    mfix();
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  // watchdog reckoned well above the expected few hundred cycles
  initial begin
    #(40 * 20000);
    num_errors++;
    test_done();
  end
  initial begin
    num_errors = 0; comparisons = 0; seed = 32'h6d9b7974;
    rst_n_in = 1'b0; {mpr, srst, hrst, psel, pen, pwr, ack_n} = 7'h00;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0; p3 = 4'h0; p41 = 1'b0; p43 = 1'b0;
    p6 = 2'h0; p5 = 8'h00; kb = 8'h00; fn = 7'h00;
    mreset();
    settle(5);
    rst_n_in <= 1'b1;
    foreach (m[k]) if (k inside {2, 4, 7, 8, 9, 10, 17, 18}) rdm(6'(k));
    apb(1'b0, 6'h3c, 8'h00, 4'h0, 8'h00);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
    // random pin patterns, then write-one and write-zero clears
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      pin(v, v[15:8] | 8'h02, 8'h00, 7'h00);
      rdm(7);
      rdm(8);
      wr(7, v[23:16] | 8'h04);
      wr(8, 8'h00);
      rdm(7);
      rdm(8);
    end
    // every function source except parallel, one at a time
    for (i = 0; i < 7; i++) begin
      pin(0, 8'h00, 8'h00, 7'h01 << i);
      rdm(9);
      wr(9, 8'hfe);
    end
    // activated parallel port follows acknowledge
    wr(18, 8'h01);
    wr(9, 8'h01);
    settle(2);
    rdm(9);
    ack_n <= 1'b1;
    settle(1);
    ack_n <= 1'b0;
    m[9] |= 1;
    rdm(9);
    // other resets only force event bit 0
    pin(32'h5a, 8'ha5, 8'h81, 7'h48);
    wr(10, 8'h3c);
    for (i = 0; i < 3; i++) begin
      wr(9, 8'h01);
      @(posedge clk_in);
      {mpr, srst, hrst} <= 3'b001 << i;
      @(posedge clk_in);
      {mpr, srst, hrst} <= 3'b000;
      m[9] |= 1;
      rdm(9);
      rdm(7);
      rdm(4);
      rdm(10);
    end
    wr(18, 8'h00);
    // wake output gating by enable, status, global and summary
    wr(10, 8'h08);
    wr(2, 8'h00);
    wr(4, 8'hff);
    wr(0, 8'h01);
    pin(0, 8'h00, 8'h08, 7'h00);
    settle(2);
    chk("wake global off", wake_n, 1);
    chk("summary", summ, 1);
    wr(2, 8'h01);
    settle(1);
    chk("wake on", wake_n, 0);
    chk("global out", gen, 1);
    wr(0, 8'h01);
    settle(1);
    chk("wake after clear", wake_n, 1);
    chk("summary clear", summ, 0);
    // fresh keyboard event with every gate open pulls wake low
    wr(4, 8'h08);
    pin(0, 8'h00, 8'h08, 7'h00);
    settle(2);
    chk("wake fresh event", wake_n, 0);
    chk("summary fresh", summ, 1);
    wr(0, 8'h01);
    settle(1);
    chk("summary cleared again", summ, 0);
    pin(0, 8'h00, 8'h04, 7'h00);
    settle(2);
    chk("wake disabled src", wake_n, 1);
    rdm(4);
    // event during a clearing write wins
    pin(0, 8'h10, 8'h00, 7'h00);
    apb(1'b1, 6'h08, 8'h10, 4'hf, 8'h10);
    rdm(8);
    apb(1'b1, 6'h0a, 8'hff, 4'h0, 8'h00);
    rdm(10);
    // interrupt raised, masked, unmasked and cleared
    wr(17, 8'h00);
    wr(16, 8'h0f);
    pin(1, 8'h00, 8'h00, 7'h00);
    settle(1);
    chk("irq masked", irq, 0);
    wr(17, 8'h02);
    settle(1);
    chk("irq unmasked", irq, 1);
    apb(1'b0, 6'h10, 8'h00, 4'h0, 8'h00);
    chk("irq pin bit", rd & 32'h2, 32'h2);
    wr(16, 8'h02);
    settle(1);
    chk("irq cleared", irq, 0);
    rdm(17);
    // standby reset mid-run zeroes everything but event bit 0
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    settle(2);
    rst_n_in <= 1'b1;
    mreset();
    foreach (m[k]) if (k inside {2, 4, 7, 8, 9, 10}) rdm(6'(k));
    test_done();
  end
endmodule
